// *** testbench/rcs_breaker_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcs_breaker_model #(
    parameter int OPERATE_CYCLES = 20
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // solenoid drives and contact status
    input wire logic trip_drive_i,
    input wire logic close_drive_i,
    output logic breaker_open_o
);
    int cnt;
    // the mechanism only moves after the solenoid has been energised for a while
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            breaker_open_o <= 1'b0;
        end else if ((trip_drive_i && !breaker_open_o) || (close_drive_i && breaker_open_o)) begin
            cnt <= cnt + 1;
            if (cnt == OPERATE_CYCLES) begin
                breaker_open_o <= trip_drive_i;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/rcs_reclose_sequencer_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcs_reclose_sequencer_sva (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic sample_start_o,
    input wire logic sample_valid_i,
    input wire logic breaker_open_i,
    input wire logic trip_drive_o,
    input wire logic close_drive_o,
    input wire logic lockout_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    a_sample_start_pulse: assert property (sample_start_o |=> !sample_start_o)
        else $error("sample request longer than one cycle");
    a_trip_after_sample: assert property ($rose(trip_drive_o) |-> $past(sample_valid_i, 2))
        else $error("trip drive not caused by a sample");
    a_trip_close_excl: assert property (!(trip_drive_o && close_drive_o))
        else $error("trip and close driven together");
    a_trip_release: assert property (
        $rose(breaker_open_i) && trip_drive_o |-> ##[1:5] !trip_drive_o)
        else $error("trip drive kept after breaker opened");
    a_close_when_open: assert property ($rose(close_drive_o) |-> breaker_open_i)
        else $error("close driven while breaker closed");
    a_lockout_no_close: assert property (lockout_o |-> !close_drive_o)
        else $error("automatic close during lockout");
    a_lockout_exit: assert property ($fell(lockout_o) |-> close_drive_o)
        else $error("lockout left without a close");
endmodule
bind rcs_reclose_sequencer rcs_reclose_sequencer_sva rcs_reclose_sequencer_sva_inst (
    .ref_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sample_start_o,
    .sample_valid_i, .breaker_open_i, .trip_drive_o, .close_drive_o, .lockout_o);
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rcs_pkg::*;
    logic ref_clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sample_valid_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, exp_ctrl, mask;
    logic sample_start_o, breaker_open_i, panel_close_i, scada_close_i;
    logic trip_drive_o, close_drive_o, lockout_o, irq_o, trip_q, close_q, open_q;
    logic signed [15:0] phase_sample_i, ground_sample_i;
    int n_errors, n_checks, n_trip, n_close, fault, gap, cyc, last_start, t;
    int open_cyc, close_cyc;
    rcs_reclose_sequencer #(.SAMPLE_DIV_LOW(20), .SAMPLE_DIV_HIGH(16), .TICK_CYCLES(10))
        rcs_reclose_sequencer_inst (.ref_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_start_o,
        .sample_valid_i, .phase_sample_i, .ground_sample_i, .breaker_open_i, .panel_close_i,
        .scada_close_i, .trip_drive_o, .close_drive_o, .lockout_o, .irq_o);
    rcs_breaker_model rcs_breaker_model_inst (.ref_clk_i, .sys_rst_i,
        .trip_drive_i(trip_drive_o), .close_drive_i(close_drive_o),
        .breaker_open_o(breaker_open_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // sample converter answers each request one cycle later; edges of the drives are counted
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        sample_valid_i <= sample_start_o;
        trip_q <= trip_drive_o;
        close_q <= close_drive_o;
        if (trip_drive_o && !trip_q) n_trip <= n_trip + 1;
        if (close_drive_o && !close_q) n_close <= n_close + 1;
        // cycle stamps of the last opening and the last close drive, for interval timing
        open_q <= breaker_open_i;
        if (breaker_open_i && !open_q) open_cyc <= cyc;
        if (close_drive_o && !close_q) close_cyc <= cyc;
        if (sample_start_o) begin
            gap <= cyc - last_start;
            last_start <= cyc;
            phase_sample_i <= fault ? 16'(16'h0400 + ($urandom & 32'hF)) : 16'($urandom & 32'h1F);
            ground_sample_i <= 16'($urandom & 32'h1F);
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int w;
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        w = 0;
        do begin
            @(posedge ref_clk_i);
            w++;
        end while (wb_ack_o !== 1'b1 && w < 50);
        if (w >= 50) n_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #800_000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, panel_close_i, scada_close_i} = '0;
        {wb_adr_i, wb_dat_i, phase_sample_i, ground_sample_i} = '0;
        {n_errors, n_checks, n_trip, n_close, fault, gap, cyc, last_start} = '0;
        {sample_valid_i, trip_q, close_q, open_q} = '0;
        {open_cyc, close_cyc} = '0;
        wb_sel_i = 4'hF;
        sys_rst_i = 1'b1;
        void'($urandom(77676));
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        wb(0, REG_CTRL, 0);
        chk("ctrl_reset", CTRL_RST, rd);
        wb(1, 8'h40, 32'hFFFF_FFFF);
        wb(0, 8'h40, 0);
        chk("unmapped", 32'h0, rd);
        wb(1, REG_RECLOSE01, 32'h0032_003C);
        wb(1, REG_RECLOSE2, 32'h0006_0028);
        for (int k = 1; k <= 4; k++) begin
            exp_ctrl = 32'(1 + 2 * (k % 2) + 4 * k);
            mask = (k == 2) ? 32'h0 : 32'hF;
            wb(1, REG_CTRL, exp_ctrl);
            wb(1, REG_IRQ_MASK, mask);
            wb(1, REG_IRQ_STAT, 32'hF);
            repeat (3) @(posedge sample_start_o);
            @(posedge ref_clk_i);
            #1 chk("sample_gap", (k % 2) ? 16 : 20, gap);
            n_trip = 0;
            n_close = 0;
            fault = 1;
            for (t = 0; t < 20000 && lockout_o !== 1'b1; t++) @(posedge ref_clk_i);
            chk("trips", k, n_trip);
            chk("closes", k - 1, n_close);
            wb(0, REG_IRQ_STAT, 0);
            chk("irq_stat", 32'(5 + 2 * (k > 1)), rd & 32'hF);
            chk("irq", {31'h0, mask != 0}, {31'h0, irq_o});
            wb(1, REG_IRQ_STAT, 32'hF);
            repeat (3) @(posedge ref_clk_i);
            chk("irq_clear", 32'h0, {31'h0, irq_o});
            fault = 0;
            repeat (30) @(posedge sample_start_o);
            chk("lockout_held", 32'h1, {31'h0, lockout_o});
            if (k % 2) panel_close_i <= 1'b1;
            else scada_close_i <= 1'b1;
            repeat (6) @(posedge ref_clk_i);
            panel_close_i <= 1'b0;
            scada_close_i <= 1'b0;
            for (t = 0; t < 2000 && breaker_open_i !== 1'b0; t++) @(posedge ref_clk_i);
            repeat (4) @(posedge ref_clk_i);
            chk("lockout_cleared", 32'h0, {31'h0, lockout_o});
            chk("ext_close", k, n_close);
        end
        // temporary fault: one trip, reclose, then back to the first step
        n_trip = 0;
        n_close = 0;
        fault = 1;
        for (t = 0; t < 20000 && n_trip == 0; t++) @(posedge ref_clk_i);
        fault = 0;
        for (t = 0; t < 2000 && breaker_open_i !== 1'b1; t++) @(posedge ref_clk_i);
        wb(1, REG_CTRL, 32'h0);
        wb(0, REG_CTRL, 0);
        chk("ctrl_frozen", exp_ctrl, rd);
        for (t = 0; t < 5000 && n_close == 0; t++) @(posedge ref_clk_i);
        repeat (300) @(posedge ref_clk_i);
        wb(0, REG_STATUS, 0);
        chk("status", 32'h0, rd & 32'h3F);
        // first interval is 0x3C ms of 10 cycles; sync and tick phase add under one tick
        chk("reclose_ms", 32'h3C, 32'((close_cyc - open_cyc + 4) / 10));
        chk("temp_trips", 32'h1, n_trip);
        chk("temp_lockout", 32'h0, {31'h0, lockout_o});
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/rcs_pkg.sv ***
`default_nettype none
package rcs_pkg;
    // clock and sampling
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SAMPLES_PER_CYCLE = 64;
    localparam int unsigned LINE_HZ_LOW = 50;
    localparam int unsigned LINE_HZ_HIGH = 60;
    localparam int unsigned SAMPLE_DIV_50 = CLK_HZ / (LINE_HZ_LOW * SAMPLES_PER_CYCLE);
    localparam int unsigned SAMPLE_DIV_60 = CLK_HZ / (LINE_HZ_HIGH * SAMPLES_PER_CYCLE);
    localparam int unsigned TICK_TIME_US = 1000;
    localparam int unsigned TICK_DIV = CLK_HZ / 1_000_000 * TICK_TIME_US;
    // filter geometry and trip limit
    localparam int unsigned AVG_LEN = 8;
    localparam int unsigned QUAD_LAG = SAMPLES_PER_CYCLE / 4;
    localparam int unsigned MAX_TRIPS = 4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CURVE_SEL = 8'h04;
    localparam logic [7:0] REG_MIN_TRIP = 8'h08;
    localparam logic [7:0] REG_CURVE_LIM0 = 8'h0C;
    localparam logic [7:0] REG_CURVE_LIM3 = 8'h18;
    localparam logic [7:0] REG_RECLOSE01 = 8'h1C;
    localparam logic [7:0] REG_RECLOSE2 = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_IRQ_STAT = 8'h28;
    localparam logic [7:0] REG_IRQ_MASK = 8'h2C;
    // ctrl fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_F60_BIT = 1;
    localparam int unsigned CTRL_TRIPS_LSB = 2;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] CURVE_SEL_RST = 32'h0000_00E4;
    localparam logic [31:0] MIN_TRIP_RST = 32'h0100_0100;
    localparam logic [31:0] CURVE_LIM_RST = 32'h0001_0000;
    localparam logic [31:0] RECLOSE01_RST = 32'h03E8_01F4;
    localparam logic [31:0] RECLOSE2_RST = 32'h2710_07D0;
    // interrupt bits
    localparam int unsigned IRQ_TRIP = 0;
    localparam int unsigned IRQ_RECLOSE = 1;
    localparam int unsigned IRQ_LOCKOUT = 2;
    localparam int unsigned IRQ_SEQ_RESET = 3;
    localparam int unsigned IRQ_W = 4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_TIMING, ST_TRIP, ST_OPEN, ST_CLOSE, ST_RESET_WAIT, ST_LOCKOUT
    } rcs_state_t;
endpackage
`default_nettype wire

// *** verilog/rcs_reclose_sequencer.sv ***
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module rcs_reclose_sequencer
    import rcs_pkg::*;
#(
    parameter int unsigned SAMPLE_DIV_LOW = SAMPLE_DIV_50,
    parameter int unsigned SAMPLE_DIV_HIGH = SAMPLE_DIV_60,
    parameter int unsigned TICK_CYCLES = TICK_DIV
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sample converter, same clock domain
    output logic sample_start_o,
    input wire logic sample_valid_i,
    input wire logic signed [15:0] phase_sample_i,
    input wire logic signed [15:0] ground_sample_i,
    // breaker interface module and close commands (pins)
    input wire logic breaker_open_i,
    input wire logic panel_close_i,
    input wire logic scada_close_i,
    output logic trip_drive_o,
    output logic close_drive_o,
    output logic lockout_o,
    output logic irq_o
);
    function automatic logic [18:0] abs19(input logic signed [18:0] v);
        abs19 = v[18] ? 19'(-v) : 19'(v);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            old[b*8 +: 8] = sel[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
        end
        merge_bytes = old;
    endfunction

    // ---------------- pin synchronisers ----------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic ext_close_prev_reg;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            ext_close_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {scada_close_i, panel_close_i, breaker_open_i};
            pin_sync_reg <= pin_meta_reg;
            ext_close_prev_reg <= pin_sync_reg[1] | pin_sync_reg[2];
        end
    end
    logic breaker_open;
    logic ext_close_req;
    assign breaker_open = pin_sync_reg[0];
    assign ext_close_req = (pin_sync_reg[1] | pin_sync_reg[2]) & ~ext_close_prev_reg;

    // ---------------- registers ----------------
    logic [31:0] ctrl_reg;
    logic [31:0] curve_sel_reg;
    logic [31:0] min_trip_reg;
    logic [31:0] curve_lim_reg [4];
    logic [31:0] reclose01_reg;
    logic [31:0] reclose2_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    rcs_state_t state_reg;
    logic [1:0] step_reg;

    logic bus_req;
    logic bus_wr;
    logic seq_busy;
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    // settings only change while no sequence runs; the write is still acknowledged
    assign seq_busy = (state_reg != ST_IDLE) && (state_reg != ST_LOCKOUT);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RST;
            curve_sel_reg <= CURVE_SEL_RST;
            min_trip_reg <= MIN_TRIP_RST;
            reclose01_reg <= RECLOSE01_RST;
            reclose2_reg <= RECLOSE2_RST;
            for (int i = 0; i < 4; i++) begin
                curve_lim_reg[i] <= CURVE_LIM_RST;
            end
        end else if (bus_wr && !seq_busy) begin
            unique case (wb_adr_i)
                REG_CTRL: ctrl_reg <= merge_bytes(ctrl_reg, wb_dat_i, wb_sel_i);
                REG_CURVE_SEL: curve_sel_reg <= merge_bytes(curve_sel_reg, wb_dat_i, wb_sel_i);
                REG_MIN_TRIP: min_trip_reg <= merge_bytes(min_trip_reg, wb_dat_i, wb_sel_i);
                REG_RECLOSE01: reclose01_reg <= merge_bytes(reclose01_reg, wb_dat_i, wb_sel_i);
                REG_RECLOSE2: reclose2_reg <= merge_bytes(reclose2_reg, wb_dat_i, wb_sel_i);
                default: begin
                    if (wb_adr_i >= REG_CURVE_LIM0 && wb_adr_i <= REG_CURVE_LIM3
                        && wb_adr_i[1:0] == 2'b00) begin
                        curve_lim_reg[2'(wb_adr_i[3:2] - REG_CURVE_LIM0[3:2])] <=
                            merge_bytes(curve_lim_reg[2'(wb_adr_i[3:2] - REG_CURVE_LIM0[3:2])],
                                        wb_dat_i, wb_sel_i);
                    end
                end
            endcase
        end
    end

    // interrupt status: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((bus_wr && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0])
                                              ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_event;
            if (bus_wr && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
            end
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // read path, registered; unmapped addresses read zero and are acknowledged
    logic above_min;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_CTRL: wb_dat_o <= ctrl_reg;
                    REG_CURVE_SEL: wb_dat_o <= curve_sel_reg;
                    REG_MIN_TRIP: wb_dat_o <= min_trip_reg;
                    REG_CURVE_LIM0: wb_dat_o <= curve_lim_reg[0];
                    8'(REG_CURVE_LIM0 + 8'h04): wb_dat_o <= curve_lim_reg[1];
                    8'(REG_CURVE_LIM0 + 8'h08): wb_dat_o <= curve_lim_reg[2];
                    REG_CURVE_LIM3: wb_dat_o <= curve_lim_reg[3];
                    REG_RECLOSE01: wb_dat_o <= reclose01_reg;
                    REG_RECLOSE2: wb_dat_o <= reclose2_reg;
                    REG_STATUS: wb_dat_o <= {24'h0, above_min, breaker_open, step_reg,
                                             1'b0, 3'(state_reg)};
                    REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_reg};
                    REG_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask_reg};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------- sample and millisecond timebases ----------------
    logic [15:0] sample_cnt_reg;
    logic [16:0] tick_cnt_reg;
    logic ms_tick;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sample_cnt_reg <= 16'h0000;
            sample_start_o <= 1'b0;
        end else if (sample_cnt_reg == 16'h0000) begin
            // divider chosen per system frequency keeps 64 samples per cycle
            sample_cnt_reg <= ctrl_reg[CTRL_F60_BIT] ? 16'(SAMPLE_DIV_HIGH - 1)
                                                     : 16'(SAMPLE_DIV_LOW - 1);
            sample_start_o <= 1'b1;
        end else begin
            sample_cnt_reg <= sample_cnt_reg - 16'h0001;
            sample_start_o <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt_reg <= 17'h00000;
        end else if (tick_cnt_reg == 17'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 17'h00000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 17'h00001;
        end
    end
    assign ms_tick = (tick_cnt_reg == 17'(TICK_CYCLES - 1));

    // ---------------- magnitude estimate, phase and ground ----------------
    // an 8-sample average nulls harmonics 8, 16, ... while keeping fundamental and DC;
    // the quadrature pair 15 samples apart (taps 0 and QUAD_LAG-1) then gives a magnitude each sample
    logic signed [15:0] raw_hist [2][AVG_LEN];
    logic signed [18:0] run_sum [2];
    logic signed [18:0] filt_hist [2][QUAD_LAG];
    logic [16:0] mag [2];
    logic signed [15:0] new_sample [2];
    assign new_sample[0] = phase_sample_i;
    assign new_sample[1] = ground_sample_i;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < 2; c++) begin
                run_sum[c] <= '0;
                for (int k = 0; k < AVG_LEN; k++) begin
                    raw_hist[c][k] <= '0;
                end
                for (int k = 0; k < QUAD_LAG; k++) begin
                    filt_hist[c][k] <= '0;
                end
            end
        end else if (sample_valid_i) begin
            for (int c = 0; c < 2; c++) begin
                run_sum[c] <= run_sum[c] + 19'(new_sample[c])
                              - 19'(raw_hist[c][AVG_LEN-1]);
                raw_hist[c][0] <= new_sample[c];
                for (int k = 1; k < AVG_LEN; k++) begin
                    raw_hist[c][k] <= raw_hist[c][k-1];
                end
                filt_hist[c][0] <= run_sum[c];
                for (int k = 1; k < QUAD_LAG; k++) begin
                    filt_hist[c][k] <= filt_hist[c][k-1];
                end
            end
        end
    end
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            mag[c] = 17'((20'(abs19(filt_hist[c][0])) + 20'(abs19(filt_hist[c][QUAD_LAG-1])))
                         >> 3);
        end
    end

    logic phase_over;
    logic ground_over;
    logic [16:0] phase_excess;
    logic [16:0] ground_excess;
    logic [16:0] excess;
    assign phase_over = mag[0] > {1'b0, min_trip_reg[15:0]};
    assign ground_over = mag[1] > {1'b0, min_trip_reg[31:16]};
    assign phase_excess = phase_over ? mag[0] - {1'b0, min_trip_reg[15:0]} : 17'h00000;
    assign ground_excess = ground_over ? mag[1] - {1'b0, min_trip_reg[31:16]} : 17'h00000;
    assign excess = (phase_excess > ground_excess) ? phase_excess : ground_excess;
    assign above_min = phase_over | ground_over;

    // ---------------- sequence ----------------
    logic [31:0] acc_reg;
    logic [15:0] timer_reg;
    logic ext_close_reg;
    logic [1:0] cur_curve;
    logic [2:0] trips_set;
    logic [15:0] interval_sel;
    assign cur_curve = curve_sel_reg[step_reg*2 +: 2];
    assign trips_set = (ctrl_reg[CTRL_TRIPS_LSB +: 3] == 3'h0) ? 3'h1
                     : (ctrl_reg[CTRL_TRIPS_LSB +: 3] > 3'(MAX_TRIPS)) ? 3'(MAX_TRIPS)
                     : ctrl_reg[CTRL_TRIPS_LSB +: 3];
    always_comb begin
        unique case (step_reg)
            2'h0: interval_sel = reclose01_reg[15:0];
            2'h1: interval_sel = reclose01_reg[31:16];
            default: interval_sel = reclose2_reg[15:0];
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            step_reg <= 2'h0;
            acc_reg <= 32'h0000_0000;
            timer_reg <= 16'h0000;
            ext_close_reg <= 1'b0;
            irq_event <= '0;
        end else begin
            irq_event <= '0;
            unique case (state_reg)
                ST_IDLE: begin
                    step_reg <= 2'h0;
                    acc_reg <= 32'h0000_0000;
                    if (ctrl_reg[CTRL_EN_BIT] && above_min && !breaker_open) begin
                        state_reg <= ST_TIMING;
                    end
                end
                ST_TIMING: begin
                    if (sample_valid_i) begin
                        if (!above_min) begin
                            // fault gone before the curve ran out
                            state_reg <= (step_reg == 2'h0) ? ST_IDLE : ST_RESET_WAIT;
                            timer_reg <= reclose2_reg[31:16];
                        end else if (acc_reg + 32'(excess) >= curve_lim_reg[cur_curve]) begin
                            state_reg <= ST_TRIP;
                            irq_event[IRQ_TRIP] <= 1'b1;
                        end else begin
                            acc_reg <= acc_reg + 32'(excess);
                        end
                    end
                end
                ST_TRIP: begin
                    if (breaker_open) begin
                        if (3'(step_reg) + 3'h1 >= trips_set) begin
                            state_reg <= ST_LOCKOUT;
                            irq_event[IRQ_LOCKOUT] <= 1'b1;
                        end else begin
                            state_reg <= ST_OPEN;
                            timer_reg <= interval_sel;
                        end
                    end
                end
                ST_OPEN: begin
                    if (timer_reg == 16'h0000) begin
                        state_reg <= ST_CLOSE;
                        step_reg <= step_reg + 2'h1;
                        ext_close_reg <= 1'b0;
                        irq_event[IRQ_RECLOSE] <= 1'b1;
                    end else if (ms_tick) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                ST_CLOSE: begin
                    acc_reg <= 32'h0000_0000;
                    if (!breaker_open) begin
                        if (ext_close_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_RESET_WAIT;
                            timer_reg <= reclose2_reg[31:16];
                        end
                    end
                end
                ST_RESET_WAIT: begin
                    if (above_min) begin
                        state_reg <= ST_TIMING;
                        acc_reg <= 32'h0000_0000;
                    end else if (timer_reg == 16'h0000) begin
                        state_reg <= ST_IDLE;
                        step_reg <= 2'h0;
                        irq_event[IRQ_SEQ_RESET] <= 1'b1;
                    end else if (ms_tick) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                ST_LOCKOUT: begin
                    // no automatic close here; only an operator command leaves lockout
                    if (ext_close_req) begin
                        state_reg <= ST_CLOSE;
                        step_reg <= 2'h0;
                        ext_close_reg <= 1'b1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trip_drive_o <= 1'b0;
            close_drive_o <= 1'b0;
            lockout_o <= 1'b0;
        end else begin
            trip_drive_o <= (state_reg == ST_TRIP) && !breaker_open;
            close_drive_o <= (state_reg == ST_CLOSE) && breaker_open;
            lockout_o <= (state_reg == ST_LOCKOUT);
        end
    end
endmodule
`default_nettype wire
